/* File: rtl/tc_cfg_pkg.sv */
// Package: offsets, field layouts and reset values of the time-constant configuration registers.
// Assumes an 8-bit register port with 6-bit addresses from the serial host front end.
package tc_cfg_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam logic [5:0] TC_ONE_OFFSET = 6'h02;
  localparam logic [5:0] TC_TWO_OFFSET = 6'h03;
  localparam logic [5:0] DIG_CONV_OFFSET = 6'h04;
  localparam logic [7:0] TC_ONE_RESET = 8'h90;
  localparam logic [7:0] TC_TWO_RESET = 8'hA0;
  localparam logic [7:0] DIG_CONV_RESET = 8'h03;
  // Field positions
  localparam int CAP_LSB = 6;
  localparam int CAP_W = 2;
  localparam int TC_ONE_RSV_BIT = 5;
  localparam int FIRST_RES_W = 5;
  localparam int SECOND_RES_W = 6;
  localparam int FREQ_LSB = 4;
  localparam int FREQ_W = 4;
  localparam int DIG_RSV_BIT = 3;
  localparam int RESP_W = 3;
  // Lowest legal periods-per-conversion code
  localparam logic [2:0] RESP_MIN_CODE = 3'h2;
endpackage

/* File: rtl/tc_cfg_regs.sv */
// Time-constant and digital conversion configuration registers.
// Assumes a synchronous register port driven by the serial host front end on SYS_CLK.
//
// Notes on behaviour
// - First time-constant register resets to 0x90: cap 7:6, reserved bit 5, res 4:0.
// - The first cap field selects 0.75, 1.5, 3 or 6 pF and resets to b10.
// - The first res field takes any 5-bit code, resets to b10000, 417k minus 12.77k per step.
// - The second time-constant register resets to 0xA0 with cap in 7:6 and res in 5:0.
// - The second cap field selects 3, 6, 12 or 24 pF and resets to b10.
// - Second res field takes any 6-bit code, resets to b100000, 835k minus 12.77k per step.
// - The digital register resets to 0x03 with lowest_sensor_freq_code in 7:4, reserved bit 3, resp in 2:0.
// - Response code b010 to b111 selects 192 to 6144 periods; host never writes b000 or b001.
`timescale 1ns/1ps
module tc_cfg_regs
  import tc_cfg_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [tc_cfg_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic [tc_cfg_pkg::DATA_W-1:0] REG_WDATA,
  output logic [tc_cfg_pkg::DATA_W-1:0] REG_RDATA,
  output logic [tc_cfg_pkg::CAP_W-1:0] FIRST_CAP_SELECT,
  output logic [tc_cfg_pkg::FIRST_RES_W-1:0] FIRST_RES_SELECT,
  output logic [tc_cfg_pkg::CAP_W-1:0] SECOND_CAP_SELECT,
  output logic [tc_cfg_pkg::SECOND_RES_W-1:0] SECOND_RES_SELECT,
  output logic [tc_cfg_pkg::FREQ_W-1:0] LOWEST_SENSOR_FREQ_CODE,
  output logic [tc_cfg_pkg::RESP_W-1:0] PERIODS_PER_CONVERSION_CODE
);
  import tc_cfg_pkg::*;

  logic [DATA_W-1:0] tc_one_ff;
  logic [DATA_W-1:0] tc_two_ff;
  logic [DATA_W-1:0] dig_conv_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;
  logic [2:0] addr_sel;

  // =====================================================
  // Address decode
  // One-hot, shared by write and read paths so both agree on the map
  function automatic logic [2:0] decode_addr(input logic [ADDR_W-1:0] addr);
    logic [2:0] sel;
    sel = 3'h0;
    if (addr == TC_ONE_OFFSET) begin
      sel = 3'h1;
    end else if (addr == TC_TWO_OFFSET) begin
      sel = 3'h2;
    end else if (addr == DIG_CONV_OFFSET) begin
      sel = 3'h4;
    end
    return sel;
  endfunction

  assign addr_sel = decode_addr(REG_ADDR);

  // =====================================================
  // Register writes
  // Reserved bits are stored as written so a readback matches the write
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      tc_one_ff <= TC_ONE_RESET;
    end else if (REG_WR && addr_sel[0]) begin
      tc_one_ff <= REG_WDATA;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      tc_two_ff <= TC_TWO_RESET;
    end else if (REG_WR && addr_sel[1]) begin
      tc_two_ff <= REG_WDATA;
    end
  end

  // Host keeps reserved response codes out; stored as written, not clamped
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      dig_conv_ff <= DIG_CONV_RESET;
    end else if (REG_WR && addr_sel[2]) begin
      dig_conv_ff <= REG_WDATA;
    end
  end

  // =====================================================
  // Read path, registered; unmapped addresses read zero
  always_comb begin
    if (addr_sel[0]) begin
      nxt_rdata = tc_one_ff;
    end else if (addr_sel[1]) begin
      nxt_rdata = tc_two_ff;
    end else if (addr_sel[2]) begin
      nxt_rdata = dig_conv_ff;
    end else begin
      nxt_rdata = 8'h00;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      rdata_ff <= 8'h00;
    end else if (REG_RD) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // =====================================================
  // Field outputs, straight from the stored registers
  assign REG_RDATA = rdata_ff;
  assign FIRST_CAP_SELECT = tc_one_ff[CAP_LSB +: CAP_W];
  assign FIRST_RES_SELECT = tc_one_ff[FIRST_RES_W-1:0];
  assign SECOND_CAP_SELECT = tc_two_ff[CAP_LSB +: CAP_W];
  assign SECOND_RES_SELECT = tc_two_ff[SECOND_RES_W-1:0];
  assign LOWEST_SENSOR_FREQ_CODE = dig_conv_ff[FREQ_LSB +: FREQ_W];
  assign PERIODS_PER_CONVERSION_CODE = dig_conv_ff[RESP_W-1:0];

  // =====================================================
  // Checks
  // Named steps shared by the properties below
  sequence s_write(logic [5:0] a);
    REG_WR && REG_ADDR == a;
  endsequence

  sequence s_read(logic [5:0] a);
    REG_RD && REG_ADDR == a;
  endsequence

  sequence s_no_write(logic [5:0] a);
    RSTN && !(REG_WR && REG_ADDR == a);
  endsequence

  // =====================================================
  // Reset defaults
  // Checked one edge after reset, so a mid-run reset is covered too
  chk_tc_one_reset: assert property (@(posedge SYS_CLK)
    !RSTN |=> tc_one_ff == 8'h90)
    else $error("first time-constant register reset value wrong");
  chk_first_cap_def: assert property (@(posedge SYS_CLK)
    !RSTN |=> FIRST_CAP_SELECT == 2'h2)
    else $error("first cap default wrong");
  chk_first_res_def: assert property (@(posedge SYS_CLK)
    !RSTN |=> FIRST_RES_SELECT == 5'h10)
    else $error("first res default wrong");
  chk_tc_two_reset: assert property (@(posedge SYS_CLK)
    !RSTN |=> tc_two_ff == 8'hA0)
    else $error("second time-constant register reset value wrong");
  chk_second_cap_def: assert property (@(posedge SYS_CLK)
    !RSTN |=> SECOND_CAP_SELECT == 2'h2)
    else $error("second cap default wrong");
  chk_second_res_def: assert property (@(posedge SYS_CLK)
    !RSTN |=> SECOND_RES_SELECT == 6'h20)
    else $error("second res default wrong");
  chk_dig_reset: assert property (@(posedge SYS_CLK)
    !RSTN |=> dig_conv_ff == 8'h03)
    else $error("digital register reset value wrong");
  chk_resp_default: assert property (@(posedge SYS_CLK)
    !RSTN |=> PERIODS_PER_CONVERSION_CODE == 3'h3 && LOWEST_SENSOR_FREQ_CODE == 4'h0)
    else $error("digital field defaults wrong");
  chk_rdata_reset: assert property (@(posedge SYS_CLK)
    !RSTN |=> REG_RDATA == 8'h00)
    else $error("read data not cleared by reset");

  // =====================================================
  // Write landing
  // Reserved bits and reserved codes land as written; the host keeps them out
  chk_first_cap_write: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    s_write(TC_ONE_OFFSET) |=> FIRST_CAP_SELECT == $past(REG_WDATA[7:6]))
    else $error("first cap field not written");
  chk_first_res_write: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    s_write(TC_ONE_OFFSET) |=> FIRST_RES_SELECT == $past(REG_WDATA[4:0]))
    else $error("first res field not written");
  chk_first_rsv_kept: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    s_write(TC_ONE_OFFSET) |=> tc_one_ff[TC_ONE_RSV_BIT] == $past(REG_WDATA[5]))
    else $error("first reserved bit not stored");
  chk_second_cap_write: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    s_write(TC_TWO_OFFSET) |=> SECOND_CAP_SELECT == $past(REG_WDATA[7:6]))
    else $error("second cap field not written");
  chk_second_res_write: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    s_write(TC_TWO_OFFSET) |=> SECOND_RES_SELECT == $past(REG_WDATA[5:0]))
    else $error("second res field not written");
  chk_freq_write: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    s_write(DIG_CONV_OFFSET) |=> LOWEST_SENSOR_FREQ_CODE == $past(REG_WDATA[7:4]))
    else $error("lowest_sensor_freq_code field not written");
  chk_resp_write: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    s_write(DIG_CONV_OFFSET) |=> PERIODS_PER_CONVERSION_CODE == $past(REG_WDATA[2:0]))
    else $error("response code not written");
  chk_unmapped_write: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    RSTN && REG_WR && REG_ADDR != TC_ONE_OFFSET && REG_ADDR != TC_TWO_OFFSET
      && REG_ADDR != DIG_CONV_OFFSET |=> $stable({tc_one_ff, tc_two_ff, dig_conv_ff}))
    else $error("write to unmapped address changed a register");

  // =====================================================
  // Hold between writes
  // RSTN in the antecedent keeps the reset edge out of the stable window
  chk_hold_value: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    s_no_write(TC_ONE_OFFSET) |=> $stable(tc_one_ff))
    else $error("first register changed without write");
  chk_hold_two: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    s_no_write(TC_TWO_OFFSET) |=> $stable(tc_two_ff))
    else $error("second register changed without write");
  chk_hold_dig: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    s_no_write(DIG_CONV_OFFSET) |=> $stable(dig_conv_ff))
    else $error("digital register changed without write");
  chk_rdata_hold: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    RSTN && !REG_RD |=> $stable(REG_RDATA))
    else $error("read data changed without read");

  // =====================================================
  // Readback
  chk_read_back: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    REG_RD && !REG_WR && REG_ADDR == DIG_CONV_OFFSET |=> REG_RDATA == dig_conv_ff)
    else $error("readback differs from stored value");
  chk_read_one: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    s_read(TC_ONE_OFFSET) |=> REG_RDATA == $past(tc_one_ff))
    else $error("first register readback wrong");
  chk_read_two: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    s_read(TC_TWO_OFFSET) |=> REG_RDATA == $past(tc_two_ff))
    else $error("second register readback wrong");
  chk_unmapped_read: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    REG_RD && REG_ADDR != TC_ONE_OFFSET && REG_ADDR != TC_TWO_OFFSET
      && REG_ADDR != DIG_CONV_OFFSET |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
endmodule // tc_cfg_regs

/* File: bench/tc_host_model.sv */
// Host model: drives the register port of the configuration registers.
// Assumes a free-running SYS_CLK from the bench.
`timescale 1ns/1ps
module tc_host_model (
  input wire logic SYS_CLK,
  output logic REG_WR,
  output logic REG_RD,
  output logic [5:0] REG_ADDR,
  output logic [7:0] REG_WDATA
);
  initial begin
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_ADDR = 6'h00;
    REG_WDATA = 8'h00;
  end
  // Callers keep reserved bits zero and response codes above b001
  task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    REG_WR <= w;
    REG_RD <= !w;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
    REG_RD <= 1'b0;
    // Released lines show no stale value
    REG_ADDR <= ~a;
    REG_WDATA <= ~d;
  endtask
endmodule // tc_host_model

/* File: bench/tb_sensor_time_constant_config_regs.sv */
// Bench: configuration registers driven through the host model.
// Assumes tc_cfg_pkg and a 50 MHz clock.
`timescale 1ns/1ps
module tb_sensor_time_constant_config_regs;
  import tc_cfg_pkg::*;
  logic SYS_CLK = 1'b0;
  logic RSTN = 1'b0;
  logic REG_WR, REG_RD;
  logic [5:0] REG_ADDR, SECOND_RES_SELECT;
  logic [7:0] REG_WDATA, REG_RDATA;
  logic [1:0] FIRST_CAP_SELECT, SECOND_CAP_SELECT;
  logic [4:0] FIRST_RES_SELECT;
  logic [3:0] LOWEST_SENSOR_FREQ_CODE;
  logic [2:0] PERIODS_PER_CONVERSION_CODE;
  int n_fail = 0;
  int comparisons = 0;
  tc_cfg_regs tc_cfg_regs_i (.SYS_CLK, .RSTN, .REG_WR, .REG_RD, .REG_ADDR, .REG_WDATA,
    .REG_RDATA, .FIRST_CAP_SELECT, .FIRST_RES_SELECT, .SECOND_CAP_SELECT,
    .SECOND_RES_SELECT, .LOWEST_SENSOR_FREQ_CODE, .PERIODS_PER_CONVERSION_CODE);
  tc_host_model tc_host_model_i (.SYS_CLK, .REG_WR, .REG_RD, .REG_ADDR, .REG_WDATA);
  initial forever #10 SYS_CLK = ~SYS_CLK;
  // ==========
  // Compare helpers
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    tc_host_model_i.acc(1'b0, a, 8'h00);
    #1 chk(24'(REG_RDATA), 24'(exp));
  endtask
  // Field outputs rebuilt as register images, reserved bits as zero
  task automatic all3(input logic [7:0] one, input logic [7:0] two, input logic [7:0] dig);
    // Settle past the launching edge before looking at the fields
    #1;
    chk({FIRST_CAP_SELECT, 1'b0, FIRST_RES_SELECT, SECOND_CAP_SELECT, SECOND_RES_SELECT,
      LOWEST_SENSOR_FREQ_CODE, 1'b0, PERIODS_PER_CONVERSION_CODE}, {one, two, dig});
    rd(TC_ONE_OFFSET, one);
    rd(TC_TWO_OFFSET, two);
    rd(DIG_CONV_OFFSET, dig);
  endtask
  // ==========
  // Scenarios
  task automatic t_reset;
    @(posedge SYS_CLK) RSTN <= 1'b0;
    repeat (2) @(posedge SYS_CLK);
    RSTN <= 1'b1;
    #1 chk(24'(REG_RDATA), 24'h00);
    all3(8'h90, 8'hA0, 8'h03);
    $display("done t_reset");
  endtask
  task automatic t_write;
    tc_host_model_i.acc(1'b1, 6'h02, 8'hDF);
    tc_host_model_i.acc(1'b1, 6'h03, 8'h7F);
    tc_host_model_i.acc(1'b1, 6'h04, 8'hF7);
    tc_host_model_i.acc(1'b1, 6'h05, 8'h00);
    all3(8'hDF, 8'h7F, 8'hF7);
    // Read data must stand across a write that is not a read
    tc_host_model_i.acc(1'b1, 6'h02, 8'hDF);
    #1 chk(24'(REG_RDATA), 24'hF7);
    rd(6'h05, 8'h00);
    $display("done t_write");
  endtask
  task automatic t_codes;
    for (int i = 2; i < 8; i++) begin
      tc_host_model_i.acc(1'b1, 6'h02, {2'(i), 1'b0, 5'(i * 5)});
      tc_host_model_i.acc(1'b1, 6'h03, {2'(i), 6'(i * 9)});
      tc_host_model_i.acc(1'b1, 6'h04, {4'(i * 2), 1'b0, 3'(i)});
      all3({2'(i), 1'b0, 5'(i * 5)}, {2'(i), 6'(i * 9)}, {4'(i * 2), 1'b0, 3'(i)});
    end
    $display("done t_codes");
  endtask
  task automatic give_verdict;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    t_reset;
    t_write;
    t_codes;
    t_reset;
    give_verdict;
  end
endmodule // tb_sensor_time_constant_config_regs
